// ### hdl/phy_ext_page_pkg.sv
// Constants and types for the extended page register bank
package phy_ext_page_pkg;
    // Register indices within a page (byte address is four times the index)
    localparam logic [4:0] IDX_ENTROPY = 5'h13;
    localparam logic [4:0] IDX_IRQ_EN = 5'h1C;
    localparam logic [4:0] IDX_IRQ_PEND = 5'h1D;
    localparam logic [4:0] IDX_RING_CTRL = 5'h1E;
    localparam logic [4:0] IDX_PAGE = 5'h1F;
    localparam logic [4:0] IDX_FIRST_PAGED = 5'h10;
    // Page select values
    localparam logic [15:0] PAGE_STD = 16'h0000;
    localparam logic [15:0] PAGE_EXT2 = 16'h0002;
    localparam logic [15:0] PAGE_EXT3 = 16'h0003;
    // Bus address layout
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 6;
    localparam int ADDR_TOP_LSB = 7;
    localparam int ADDR_TOP_MSB = 11;
    // Interrupt source bit positions
    localparam int IRQ_BITS = 11;
    localparam int IRQ_MEM_RING = 10;
    localparam int IRQ_SEC_EGRESS = 9;
    localparam int IRQ_SEC_INGRESS = 8;
    localparam int IRQ_SEC_FCBUF = 7;
    localparam int IRQ_LINE_MAC = 6;
    localparam int IRQ_HOST_MAC = 5;
    localparam int IRQ_RING_DONE = 4;
    localparam int IRQ_EEE_LINK_FAIL = 3;
    localparam int IRQ_RECEIVE_QUIET_TIMER = 2;
    localparam int IRQ_RECEIVE_WAIT_TIMER = 1;
    localparam int IRQ_EEE_WAKE_ERR = 0;
    localparam logic [10:0] IRQ_RESET = 11'h000;
    // Ring failover control field positions
    localparam int RF_STARTUP_BIT = 15;
    localparam int RF_ADVERTISE_BIT = 14;
    localparam int RF_LP_ADV_BIT = 13;
    localparam int RF_FORCE_BIT = 12;
    localparam int RF_STATUS_LSB = 4;
    localparam int RF_STATUS_MSB = 5;
    localparam int RF_START_BIT = 0;
    localparam logic [1:0] RF_CODE_SLAVE = 2'b00;
    localparam logic [1:0] RF_CODE_M2S = 2'b01;
    localparam logic [1:0] RF_CODE_S2M = 2'b10;
    localparam logic [1:0] RF_CODE_MASTER = 2'b11;
    // Switchover duration
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SWITCH_TIME_NS = 1000;
    localparam logic [7:0] SWITCH_CYCLES = 8'((SWITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Entropy generator
    localparam logic [15:0] ENTROPY_SEED = 16'hACE1;
    localparam logic [15:0] ENTROPY_POLY = 16'hB400;
    // Ring failover role states
    typedef enum logic [1:0] {
        RF_SLAVE,
        RF_SLAVE_TO_MASTER,
        RF_MASTER,
        RF_MASTER_TO_SLAVE
    } ring_failover_state_t;
endpackage

// ### hdl/phy_ext_page_irq_ring_regs.sv
// Extended page register bank: entropy, interrupts, ring failover, page decode
`timescale 1ns/1ps
module phy_ext_page_irq_ring_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Device events and link state
    input wire logic soft_reset,
    input wire logic [10:0] ext_event,
    input wire logic link_up,
    input wire logic an_master,
    input wire logic lp_ring_adv,
    // Interrupt
    output logic irq,
    // Ring failover outputs
    output logic ring_startup_master_enable,
    output logic ring_advertise,
    output logic ring_force,
    output logic [1:0] ring_status,
    // Forwarded accesses to registers not served here: standard set below index 16, selected page above
    output logic route_valid,
    output logic [15:0] route_page,
    output logic [4:0] route_index,
    output logic route_write,
    output logic [15:0] route_wdata
);

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
        logic [15:0] page;
        logic [10:0] irq_en;
        logic [10:0] pend;
        logic rf_startup;
        logic rf_adv;
        logic rf_force;
        logic rf_start;
        logic rf_lp_adv;
        phy_ext_page_pkg::ring_failover_state_t rf_state;
        logic [1:0] rf_code;
        logic [7:0] sw_count;
        logic link_q;
        logic [15:0] entropy;
        logic route_valid;
        logic [15:0] route_page;
        logic [4:0] route_index;
        logic route_write;
        logic [15:0] route_wdata;
    } regs_state_t;

    regs_state_t s;
    regs_state_t next_s;

    logic [4:0] idx;
    logic addr_ok;
    logic local_hit;
    logic [15:0] rd_word;
    logic [10:0] clr_mask;
    logic [10:0] events;
    logic sw_done;
    logic rf_stable;

    // Pending value left by a soft reset
    localparam logic [10:0] IRQ_SOFT_CLEAR = phy_ext_page_pkg::IRQ_RESET;

    // Status code for each role state
    function automatic logic [1:0] code_of(input phy_ext_page_pkg::ring_failover_state_t st);
        logic [1:0] c;
        c = phy_ext_page_pkg::RF_CODE_SLAVE;
        unique case (st)
            phy_ext_page_pkg::RF_SLAVE: c = phy_ext_page_pkg::RF_CODE_SLAVE;
            phy_ext_page_pkg::RF_SLAVE_TO_MASTER: c = phy_ext_page_pkg::RF_CODE_S2M;
            phy_ext_page_pkg::RF_MASTER: c = phy_ext_page_pkg::RF_CODE_MASTER;
            phy_ext_page_pkg::RF_MASTER_TO_SLAVE: c = phy_ext_page_pkg::RF_CODE_M2S;
        endcase
        return c;
    endfunction

    // Address decode
    assign idx = paddr[phy_ext_page_pkg::ADDR_IDX_MSB:phy_ext_page_pkg::ADDR_IDX_LSB];
    assign addr_ok = (paddr[phy_ext_page_pkg::ADDR_TOP_MSB:phy_ext_page_pkg::ADDR_TOP_LSB] == 5'h00)
                     && (paddr[31:12] == 20'h00000) && (paddr[1:0] == 2'h0);
    assign rf_stable = (s.rf_state == phy_ext_page_pkg::RF_SLAVE) || (s.rf_state == phy_ext_page_pkg::RF_MASTER);

    // Served here: page select always, own registers only on page two
    always_comb begin
        local_hit = 1'b0;
        if (idx == phy_ext_page_pkg::IDX_PAGE) begin
            local_hit = 1'b1;
        end else if (idx >= phy_ext_page_pkg::IDX_FIRST_PAGED && s.page == phy_ext_page_pkg::PAGE_EXT2) begin
            unique case (idx)
                phy_ext_page_pkg::IDX_ENTROPY,
                phy_ext_page_pkg::IDX_IRQ_EN,
                phy_ext_page_pkg::IDX_IRQ_PEND,
                phy_ext_page_pkg::IDX_RING_CTRL: local_hit = 1'b1;
                default: local_hit = 1'b0;
            endcase
        end
    end

    // Read multiplexer for local registers
    always_comb begin
        rd_word = 16'h0000;
        if (local_hit) begin
            unique case (idx)
                phy_ext_page_pkg::IDX_PAGE: rd_word = s.page;
                phy_ext_page_pkg::IDX_ENTROPY: rd_word = s.entropy;
                phy_ext_page_pkg::IDX_IRQ_EN: rd_word = {5'h00, s.irq_en};
                phy_ext_page_pkg::IDX_IRQ_PEND: rd_word = {5'h00, s.pend};
                phy_ext_page_pkg::IDX_RING_CTRL: begin
                    rd_word[phy_ext_page_pkg::RF_STARTUP_BIT] = s.rf_startup;
                    rd_word[phy_ext_page_pkg::RF_ADVERTISE_BIT] = s.rf_adv;
                    rd_word[phy_ext_page_pkg::RF_LP_ADV_BIT] = s.rf_lp_adv;
                    rd_word[phy_ext_page_pkg::RF_FORCE_BIT] = s.rf_force;
                    rd_word[phy_ext_page_pkg::RF_STATUS_MSB:phy_ext_page_pkg::RF_STATUS_LSB] = s.rf_code;
                    rd_word[phy_ext_page_pkg::RF_START_BIT] = s.rf_start;
                end
                default: rd_word = 16'h0000;
            endcase
        end
    end

    // Next-state logic
    always_comb begin
        next_s = s;
        clr_mask = 11'h000;
        sw_done = 1'b0;
        events = ext_event;
        events[phy_ext_page_pkg::IRQ_RING_DONE] = 1'b0;

        // Free-running entropy source
        next_s.entropy = {s.entropy[14:0], 1'b0} ^ (s.entropy[15] ? phy_ext_page_pkg::ENTROPY_POLY : 16'h0000);
        next_s.rf_lp_adv = lp_ring_adv;
        next_s.link_q = link_up;
        next_s.rf_start = 1'b0;
        next_s.route_valid = 1'b0;
        next_s.irq = |(s.pend & s.irq_en);

        // Ring failover role machine
        unique case (s.rf_state)
            phy_ext_page_pkg::RF_SLAVE: begin
                if (s.rf_start) begin
                    next_s.rf_state = phy_ext_page_pkg::RF_SLAVE_TO_MASTER;
                    next_s.sw_count = 8'h00;
                end else if (link_up && !s.link_q && an_master) begin
                    next_s.rf_state = phy_ext_page_pkg::RF_MASTER;
                end
            end
            phy_ext_page_pkg::RF_MASTER: begin
                if (s.rf_start) begin
                    next_s.rf_state = phy_ext_page_pkg::RF_MASTER_TO_SLAVE;
                    next_s.sw_count = 8'h00;
                end else if (link_up && !s.link_q && !an_master) begin
                    next_s.rf_state = phy_ext_page_pkg::RF_SLAVE;
                end
            end
            phy_ext_page_pkg::RF_SLAVE_TO_MASTER,
            phy_ext_page_pkg::RF_MASTER_TO_SLAVE: begin
                if (s.sw_count == phy_ext_page_pkg::SWITCH_CYCLES - 8'h01) begin
                    sw_done = 1'b1;
                    next_s.rf_state = (s.rf_state == phy_ext_page_pkg::RF_SLAVE_TO_MASTER)
                                      ? phy_ext_page_pkg::RF_MASTER : phy_ext_page_pkg::RF_SLAVE;
                end else begin
                    next_s.sw_count = s.sw_count + 8'h01;
                end
            end
        endcase

        // APB: one wait state, effects at the completing edge
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !addr_ok;
            next_s.prdata = (addr_ok && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
        end else if (psel && penable && s.pready) begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
            if (addr_ok && local_hit) begin
                if (pwrite) begin
                    unique case (idx)
                        phy_ext_page_pkg::IDX_PAGE: next_s.page = pwdata[15:0];
                        phy_ext_page_pkg::IDX_IRQ_EN: next_s.irq_en = pwdata[10:0];
                        phy_ext_page_pkg::IDX_IRQ_PEND: clr_mask = pwdata[10:0];
                        phy_ext_page_pkg::IDX_RING_CTRL: begin
                            next_s.rf_startup = pwdata[phy_ext_page_pkg::RF_STARTUP_BIT];
                            next_s.rf_adv = pwdata[phy_ext_page_pkg::RF_ADVERTISE_BIT];
                            next_s.rf_force = pwdata[phy_ext_page_pkg::RF_FORCE_BIT];
                            next_s.rf_start = pwdata[phy_ext_page_pkg::RF_START_BIT] && rf_stable
                                              && !s.rf_start;
                        end
                        default: next_s.page = s.page;
                    endcase
                end else if (idx == phy_ext_page_pkg::IDX_IRQ_PEND) begin
                    clr_mask = s.prdata[10:0];
                end
            end else if (addr_ok) begin
                next_s.route_valid = 1'b1;
                next_s.route_index = idx;
                next_s.route_page = (idx < phy_ext_page_pkg::IDX_FIRST_PAGED)
                                    ? phy_ext_page_pkg::PAGE_STD : s.page;
                next_s.route_write = pwrite;
                next_s.route_wdata = pwdata[15:0];
            end
        end else begin
            next_s.pready = 1'b0;
        end

        // Pending bits: a new event wins over a clear
        next_s.pend = (s.pend & ~clr_mask) | events;
        next_s.pend[phy_ext_page_pkg::IRQ_RING_DONE] = (s.pend[phy_ext_page_pkg::IRQ_RING_DONE]
            & ~clr_mask[phy_ext_page_pkg::IRQ_RING_DONE]) | sw_done;

        // Soft reset clears non-sticky state only
        if (soft_reset) begin
            next_s.pend = IRQ_SOFT_CLEAR;
            next_s.rf_state = phy_ext_page_pkg::RF_SLAVE;
            next_s.sw_count = 8'h00;
            next_s.rf_start = 1'b0;
        end
        next_s.rf_code = code_of(next_s.rf_state);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.entropy <= phy_ext_page_pkg::ENTROPY_SEED;
            s.page <= phy_ext_page_pkg::PAGE_STD;
            s.irq_en <= phy_ext_page_pkg::IRQ_RESET;
            s.pend <= phy_ext_page_pkg::IRQ_RESET;
            s.rf_state <= phy_ext_page_pkg::RF_SLAVE;
            s.rf_code <= phy_ext_page_pkg::RF_CODE_SLAVE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops
    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign ring_startup_master_enable = s.rf_startup;
    assign ring_advertise = s.rf_adv;
    assign ring_force = s.rf_force;
    assign ring_status = s.rf_code;
    assign route_valid = s.route_valid;
    assign route_page = s.route_page;
    assign route_index = s.route_index;
    assign route_write = s.route_write;
    assign route_wdata = s.route_wdata;

endmodule

// ### bench/phy_ext_page_irq_ring_regs_props.sv
// Port checker for the extended page register bank
`timescale 1ns/1ps
module phy_ext_page_irq_ring_regs_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Device side
    input wire logic soft_reset,
    input wire logic ring_startup_master_enable,
    input wire logic ring_advertise,
    input wire logic ring_force,
    input wire logic [1:0] ring_status,
    input wire logic route_valid,
    input wire logic [15:0] route_page
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] wd_q;
    logic [8:0] trans_cnt;
    logic trans;
    logic ctrl_wr;
    // Role change in progress, ring control write completing
    assign trans = ring_status[1] ^ ring_status[0];
    assign ctrl_wr = psel && pready && pwrite && !pslverr && paddr == 32'h00000078;
    // Write data from the previous cycle and length of the current role change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= 32'h00000000;
            trans_cnt <= 9'h000;
        end else begin
            wd_q <= pwdata;
            trans_cnt <= trans ? trans_cnt + 9'h001 : 9'h000;
        end
    end
    // Access phase, then a one-cycle answer
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_one_wait; s_wait |=> s_answer; endproperty
    property p_ready_in_access; pready |-> psel && penable && $past(penable); endproperty
    property p_low_route;
        psel && pready && !pslverr && paddr < 32'h00000040 |=> route_valid && route_page == 16'h0000;
    endproperty
    property p_sticky_hold; !ctrl_wr |=> $stable({ring_startup_master_enable, ring_advertise, ring_force}); endproperty
    property p_sticky_write;
        ctrl_wr |=> route_valid || {ring_startup_master_enable, ring_advertise, ring_force} == {wd_q[15:14], wd_q[12]};
    endproperty
    property p_s2m; ring_status == 2'b10 && !soft_reset |=> ring_status inside {2'b10, 2'b11}; endproperty
    property p_m2s; ring_status == 2'b01 && !soft_reset |=> ring_status inside {2'b01, 2'b00}; endproperty
    property p_switch_len; $fell(trans) && !$past(soft_reset) |-> trans_cnt == 9'h0C8; endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer not one cycle after access");
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    a_low_route: assert property (p_low_route) else $error("low register not routed to standard set");
    a_sticky_hold: assert property (p_sticky_hold) else $error("ring control bit changed without write");
    a_sticky_write: assert property (p_sticky_write) else $error("ring control bits differ from write");
    a_s2m: assert property (p_s2m) else $error("bad exit from slave becoming master");
    a_m2s: assert property (p_m2s) else $error("bad exit from master becoming slave");
    a_switch_len: assert property (p_switch_len) else $error("switchover length wrong");
endmodule
bind phy_ext_page_irq_ring_regs phy_ext_page_irq_ring_regs_props u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .soft_reset, .ring_startup_master_enable, .ring_advertise,
    .ring_force, .ring_status, .route_valid, .route_page);

// ### bench/phy_ext_page_irq_ring_regs_tb_top.sv
// Self-checking bench for the extended page register bank
`timescale 1ns/1ps
module phy_ext_page_irq_ring_regs_tb_top;
    typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, prdata, rdata, ent_q;
    logic pready, pslverr, irq, ring_startup_master_enable, ring_advertise, ring_force, route_valid, route_write, err;
    logic rt_wr;
    logic soft_reset = 1'b0, link_up = 1'b0, an_master = 1'b0, lp_ring_adv = 1'b0;
    logic [10:0] ext_event = 11'h000;
    logic [1:0] ring_status;
    logic [15:0] route_page, route_wdata, rt_page, rt_wd;
    logic [4:0] route_index, rt_idx;
    int n_errors = 0, compares = 0;
    row_t rows [0:11] = '{'{1'b1, 32'h7C, 32'h2, 32'h0, 1'b0}, '{1'b0, 32'h7C, 32'h0, 32'h2, 1'b0},
        '{1'b0, 32'h70, 32'h0, 32'h0, 1'b0}, '{1'b0, 32'h74, 32'h0, 32'h0, 1'b0},
        '{1'b0, 32'h78, 32'h0, 32'h0, 1'b0}, '{1'b1, 32'h70, 32'h7FF, 32'h0, 1'b0},
        '{1'b0, 32'h70, 32'h0, 32'h7FF, 1'b0}, '{1'b1, 32'h78, 32'hD000, 32'h0, 1'b0},
        '{1'b0, 32'h78, 32'h0, 32'hD000, 1'b0}, '{1'b1, 32'h4C, 32'hFFFF, 32'h0, 1'b0},
        '{1'b0, 32'h80, 32'h0, 32'h0, 1'b1}, '{1'b1, 32'h72, 32'h1, 32'h0, 1'b1}};
    phy_ext_page_irq_ring_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .soft_reset, .ext_event, .link_up, .an_master, .lp_ring_adv, .irq, .ring_startup_master_enable,
        .ring_advertise, .ring_force, .ring_status, .route_valid, .route_page, .route_index, .route_write,
        .route_wdata);
    // Clock and forwarded access capture
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (route_valid === 1'b1) begin
        rt_page <= route_page;
        rt_idx <= route_index;
        rt_wr <= route_write;
        rt_wd <= route_wdata;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the completing edge; the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        repeat (8000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("error flag", {31'h0, rows[i].err}, {31'h0, err});
            if (!rows[i].wr) chk("read data", rows[i].e, rdata);
        end
        apb(1'b0, 32'h4C, 32'h0);
        ent_q = rdata;
        apb(1'b0, 32'h4C, 32'h0);
        chk("entropy moves", 32'h1, {31'h0, rdata !== ent_q});
        chk("entropy upper half", 32'h0, {16'h0000, rdata[31:16]});
        for (int i = 0; i < 11; i++) begin
            if (i == 4) continue;
            ext_event <= 11'h001 << i;
            @(posedge pclk);
            ext_event <= 11'h000;
            repeat (2) @(posedge pclk);
            chk("irq raised", 32'h1, {31'h0, irq});
            apb(1'b0, 32'h74, 32'h0);
            chk("pending", 32'h1 << i, rdata);
            apb(1'b0, 32'h74, 32'h0);
            chk("pending cleared", 32'h0, rdata);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        apb(1'b1, 32'h70, 32'h1);
        ext_event <= 11'h002;
        @(posedge pclk);
        ext_event <= 11'h000;
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        apb(1'b0, 32'h74, 32'h0);
        chk("pending after soft reset", 32'h0, rdata);
        apb(1'b0, 32'h70, 32'h0);
        chk("enable after soft reset", 32'h1, rdata);
        apb(1'b1, 32'h70, 32'h10);
        lp_ring_adv <= 1'b1;
        link_up <= 1'b1;
        an_master <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("role at link up", 32'h3, {30'h0, ring_status});
        apb(1'b0, 32'h78, 32'h0);
        chk("ring control", 32'hF030, rdata);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, 32'h78, 32'hD001);
            repeat (3) @(posedge pclk);
            chk("role changing", j ? 32'h2 : 32'h1, {30'h0, ring_status});
            apb(1'b1, 32'h78, 32'hD001);
            for (int n = 0; n < 300 && (ring_status[1] ^ ring_status[0]) === 1'b1; n++) @(posedge pclk);
            repeat (3) @(posedge pclk);
            chk("role settled", j ? 32'h3 : 32'h0, {30'h0, ring_status});
            chk("irq on switchover", 32'h1, {31'h0, irq});
            apb(1'b0, 32'h74, 32'h0);
            chk("switchover pending", 32'h10, rdata);
        end
        apb(1'b1, 32'h7C, 32'h3);
        apb(1'b0, 32'h74, 32'h0);
        repeat (2) @(posedge pclk);
        chk("third page route", 32'h0003001D, {rt_page, 11'h000, rt_idx});
        apb(1'b1, 32'h08, 32'h5);
        repeat (2) @(posedge pclk);
        chk("low register route", 32'h00000002, {rt_page, 11'h000, rt_idx});
        chk("low register route data", 32'h00010005, {15'h0000, rt_wr, rt_wd});
        apb(1'b1, 32'h7C, 32'h0);
        apb(1'b0, 32'h70, 32'h0);
        repeat (2) @(posedge pclk);
        chk("standard page route", 32'h0000001C, {rt_page, 11'h000, rt_idx});
        chk("routed read data", 32'h0, rdata);
        end_of_test();
    end
endmodule
